// file: sbarb_pkg.sv
/*
  Shared types and constants for the system bus arbiter and region guard.
  Assumes one system clock; all users refer to names as sbarb_pkg::name.
*/
package sbarb_pkg;

  localparam int NINIT = 14;
  localparam int NTGT = 13;
  localparam int NREG = 3;

  // Initiator request, held until granted
  typedef struct packed {
    logic req;
    logic wr;
    logic [31:0] addr;
  } sbarb_ireq_t;

  typedef struct packed {
    logic gnt;
    logic err;
  } sbarb_iresp_t;

  typedef struct packed {
    logic valid;
    logic wr;
    logic [3:0] init;
  } sbarb_tsel_t;

  typedef struct packed {
    logic [21:0] base;
    logic region_precedence;
    logic [4:0] size;
  } sbarb_desc_t;

  typedef struct packed {
    logic multi;
    logic [1:0] grp;
    logic [4:0] init_id;
    logic [3:0] tgt;
    logic [1:0] region;
    logic wr;
    logic valid;
  } sbarb_log_t;

  // Register offsets
  localparam logic [11:0] OFS_CFG0 = 12'h000;
  localparam logic [11:0] OFS_CFG = 12'h004;
  localparam logic [11:0] OFS_GRP = 12'h008;
  localparam logic [11:0] OFS_KEY = 12'h00c;
  localparam logic [11:0] OFS_LOG = 12'h010;
  localparam logic [11:0] OFS_LOGCLR = 12'h014;
  localparam logic [11:0] OFS_REGION = 12'h100;
  localparam logic [3:0] WORD_DESC = 4'h0;
  localparam logic [3:0] WORD_RD = 4'h1;
  localparam logic [3:0] WORD_WR = 4'h2;

  // Config bit positions
  localparam int CFG0_FC = 5;
  localparam int CFG0_DMA = 6;
  localparam int CFG0_CPU = 7;
  localparam int CFG_LOCK = 11;

  // Unlock keys, values arbitrary
  localparam logic [31:0] KEY_FIRST = 32'h1234_5678;
  localparam logic [31:0] KEY_SECOND = 32'h8765_4321;

  // Initiator indices
  localparam logic [3:0] INI_CPU = 4'h0;
  localparam logic [3:0] INI_FC = 4'h1;
  localparam logic [3:0] INI_DMARD = 4'h2;
  localparam logic [3:0] INI_DMAWR = 4'h3;
  localparam logic [4:0] ID_FIRST_SHARED = 5'h5;
  localparam logic [1:0] REGION_NONE = 2'h3;

  // Connectivity, one row per target, bit per initiator
  localparam logic [12:0][13:0] CONN = {
    14'h001f, 14'h001f, 14'h001f, 14'h001f, 14'h0017, 14'h001f,
    14'h001f, 14'h001f, 14'h0011, 14'h3fe5, 14'h3fff, 14'h3fff,
    14'h3fff};

  // Fixed region 0 base (address >> 10) and size code
  localparam logic [12:0][21:0] FIX_BASE = {
    22'h07e384, 22'h07e390, 22'h07e100, 22'h07e3c0, 22'h07e1c0,
    22'h07e300, 22'h07e080, 22'h07e000, 22'h040000, 22'h042000,
    22'h000100, 22'h000080, 22'h000000};
  localparam logic [12:0][4:0] FIX_SIZE = {
    5'h03, 5'h09, 5'h08, 5'h07, 5'h08, 5'h08, 5'h08, 5'h08,
    5'h0b, 5'h0b, 5'h07, 5'h08, 5'h08};

  // Targets with programmable regions 1 and 2
  localparam logic [12:0] PROG_TGT = 13'h080f;
  localparam logic [12:0] SRAM_TGT = 13'h0003;
  localparam logic [12:0] NOWRITE_TGT = 13'h0018;
  localparam int TGT_FABRIC = 9;
  localparam logic [3:0] PERM_PERM_GROUP_ZERO = 4'h1;
  localparam logic [3:0] PERM_ALL = 4'hf;

  // Precedence level of each region slot
  localparam logic [2:0][1:0] REGION_LEVEL = {2'h1, 2'h3, 2'h0};

endpackage

// file: sbarb_lrs.sv
/*
  Least-recently-served arbiter for one target, with fixed-high override.
  Assumes requests are held until granted; ranks update on every grant.
*/
`timescale 1ns/1ps
module sbarb_lrs (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [13:0] req,
  input wire logic [13:0] high,
  output logic [13:0] gnt
);

  typedef struct packed {
    logic [13:0][3:0] rank;
  } sbarb_lrs_state_t;

  sbarb_lrs_state_t s_q;
  sbarb_lrs_state_t s_d;
  logic [13:0] cand;
  logic [3:0] best;
  logic [3:0] win;

  always_comb
  begin
    s_d = s_q;
    gnt = '0;
    best = 4'hf;
    win = '0;
    // High requesters shadow all others
    cand = (|(req & high)) ? (req & high) : req;
    for (int i = 0; i < 14; i++)
    begin
      if (cand[i] && s_q.rank[i] < best)
      begin
        best = s_q.rank[i];
        win = 4'(i);
      end
    end
    if (|cand)
    begin
      gnt[win] = 1'b1;
      for (int i = 0; i < 14; i++)
      begin
        if (s_q.rank[i] > best)
        begin
          s_d.rank[i] = s_q.rank[i] - 4'h1;
        end
      end
      s_d.rank[win] = 4'hd;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 14; i++)
      begin
        s_q.rank[i] <= 4'(i);
      end
    end
    else
    begin
      s_q <= s_d;
    end
  end

endmodule

// file: sbarb_top.sv
/*
  System bus arbiter and region guard with APB register access.
  Assumes initiators hold req, wr and addr until gnt; a grant with err
  means the access was blocked. Targets act on tsel in the grant cycle.
*/
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ps
// Operation
// - Route only marked initiator-target links
// - Flash target reachable by processor and debugger
// - Calendar target not reachable by DMA write
// - Fixed least-recently-served order by default
// - Initiator identifiers one to eighteen
// - SRAM high priority picked by config bits
// - High priority beats least-recently-served
// - Three regions on programmable targets, one on others, gated by groups
// - Each initiator carries one of four groups
// - Separate read and write enables per group
// - Lock bit blocks region and permission writes
// - Base field holds address shifted by ten
// - Size code gives two power code-minus-one KB
// - Fixed region fields loaded at reset
// - Programmable read permissions reset to ones
// - Different targets served at same time
// - Processor group cleared on reset or NMI
module sbarb_top (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire sbarb_pkg::sbarb_ireq_t [13:0] ireq,
  output sbarb_pkg::sbarb_iresp_t [13:0] iresp,
  output sbarb_pkg::sbarb_tsel_t [12:0] tsel,
  input wire logic cpu_exception_level,
  input wire logic nmi_event
);

  typedef struct packed {
    logic [2:0] hi_sel;
    logic lock;
    logic [27:0] grp;
    logic [1:0] key_state;
    sbarb_pkg::sbarb_desc_t [12:0][2:0] desc;
    logic [12:0][2:0][3:0] rperm;
    logic [12:0][2:0][3:0] wperm;
    sbarb_pkg::sbarb_log_t log;
    logic [31:0] rdata;
    logic slverr;
  } sbarb_state_t;

  sbarb_state_t s_q;
  sbarb_state_t s_d;
  logic rst_meta_q;
  logic rst_sync_q;
  logic [12:0][13:0] treq;
  logic [12:0][13:0] thigh;
  logic [12:0][13:0] tgnt;
  logic [13:0][3:0] tix;
  logic [13:0] thit;

  // Reset release through two flops
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // Region hit at 1 KB granularity
  function automatic logic region_hit(input logic [21:0] akb,
                                      input sbarb_pkg::sbarb_desc_t d);
    logic [21:0] len;
    len = (d.size == 5'h00) ? 22'h0 : 22'(22'h1 << (d.size - 5'h01));
    return (len != 22'h0) && ((akb - d.base) < len);
  endfunction

  function automatic sbarb_pkg::sbarb_desc_t eff_desc(input sbarb_state_t s,
                                                      input int t,
                                                      input int r);
    sbarb_pkg::sbarb_desc_t d;
    d = '0;
    if (r == 0)
    begin
      d.base = sbarb_pkg::FIX_BASE[t];
      d.size = sbarb_pkg::FIX_SIZE[t];
    end
    else if (sbarb_pkg::PROG_TGT[t])
    begin
      d = s.desc[t][r];
    end
    return d;
  endfunction

  function automatic logic [3:0] eff_perm(input sbarb_state_t s,
                                          input int t,
                                          input int r,
                                          input logic wr);
    logic [3:0] p;
    p = wr ? s.wperm[t][r] : s.rperm[t][r];
    if (t == sbarb_pkg::TGT_FABRIC)
    begin
      p = sbarb_pkg::PERM_PERM_GROUP_ZERO;
    end
    else if (wr && sbarb_pkg::NOWRITE_TGT[t])
    begin
      p = '0;
    end
    return p;
  endfunction

  function automatic logic [4:0] init_id(input int i, input logic hi);
    logic [4:0] id;
    if (i < 4)
    begin
      id = 5'(2 * i + 1) + {4'h0, hi};
    end
    else
    begin
      id = 5'(i) + sbarb_pkg::ID_FIRST_SHARED;
    end
    return id;
  endfunction

  // Address decode against fixed target windows
  always_comb
  begin
    for (int i = 0; i < 14; i++)
    begin
      tix[i] = '0;
      thit[i] = 1'b0;
      for (int t = 12; t >= 0; t--)
      begin
        if (region_hit(ireq[i].addr[31:10], eff_desc(s_q, t, 0)))
        begin
          tix[i] = 4'(t);
          thit[i] = 1'b1;
        end
      end
    end
  end

  always_comb
  begin
    for (int t = 0; t < 13; t++)
    begin
      for (int i = 0; i < 14; i++)
      begin
        // Unmarked pairings never reach the target
        treq[t][i] = ireq[i].req && thit[i] && tix[i] == 4'(t)
                     && sbarb_pkg::CONN[t][i];
        thigh[t][i] = 1'b0;
      end
      if (sbarb_pkg::SRAM_TGT[t])
      begin
        thigh[t][sbarb_pkg::INI_CPU] = s_q.hi_sel[2]
                                       && cpu_exception_level;
        thigh[t][sbarb_pkg::INI_FC] = s_q.hi_sel[0];
        thigh[t][sbarb_pkg::INI_DMARD] = s_q.hi_sel[1];
        thigh[t][sbarb_pkg::INI_DMAWR] = s_q.hi_sel[1];
      end
    end
  end

  // One arbiter per target, so distinct targets proceed together
  genvar gt;
  generate
    for (gt = 0; gt < 13; gt++)
    begin : g_arb
      sbarb_lrs u_lrs (
        .clk_sys(clk_sys),
        .rst_n(rst_sync_q),
        .req(treq[gt]),
        .high(thigh[gt]),
        .gnt(tgnt[gt])
      );
    end
  endgenerate

  always_comb
  begin
    logic [3:0] w;
    logic [1:0] g;
    logic [1:0] best_lvl;
    logic found;
    logic allow;
    logic vio_seen;
    logic [11:0] off;
    logic [3:0] rt;
    logic [3:0] rr;
    logic [3:0] rw;
    logic rvalid;
    logic wen;
    logic [3:0] perm;
    logic log_clr;
    w = '0;
    g = '0;
    best_lvl = '0;
    found = 1'b0;
    allow = 1'b0;
    vio_seen = 1'b0;
    perm = '0;
    rr = {2'h0, sbarb_pkg::REGION_NONE};
    rvalid = 1'b0;
    off = paddr[11:0] - sbarb_pkg::OFS_REGION;
    rt = off[9:6];
    rw = {2'h0, off[3:2]};
    wen = psel && penable && pwrite;
    log_clr = wen && paddr[11:0] == sbarb_pkg::OFS_LOGCLR;
    s_d = s_q;
    iresp = '0;
    tsel = '0;
    // Unconnected or unmapped requests end at once with an error
    for (int i = 0; i < 14; i++)
    begin
      if (ireq[i].req && !(thit[i] && sbarb_pkg::CONN[tix[i]][i]))
      begin
        iresp[i].gnt = 1'b1;
        iresp[i].err = 1'b1;
      end
    end
    for (int t = 0; t < 13; t++)
    begin
      w = '0;
      for (int i = 0; i < 14; i++)
      begin
        if (tgnt[t][i])
        begin
          w = 4'(i);
        end
      end
      if (|tgnt[t])
      begin
        g = s_q.grp[2 * w +: 2];
        found = 1'b0;
        best_lvl = '0;
        allow = 1'b0;
        rr = {2'h0, sbarb_pkg::REGION_NONE};
        for (int r = 0; r < 3; r++)
        begin
          if (region_hit(ireq[w].addr[31:10], eff_desc(s_q, t, r))
              && (!found || sbarb_pkg::REGION_LEVEL[r] > best_lvl))
          begin
            found = 1'b1;
            best_lvl = sbarb_pkg::REGION_LEVEL[r];
            perm = eff_perm(s_q, t, r, ireq[w].wr);
            allow = perm[g];
            rr = 4'(r);
          end
        end
        iresp[w].gnt = 1'b1;
        iresp[w].err = !allow;
        tsel[t].valid = allow;
        tsel[t].wr = ireq[w].wr;
        tsel[t].init = w;
        if (!allow && !vio_seen)
        begin
          vio_seen = 1'b1;
          if (s_q.log.valid && !log_clr)
          begin
            s_d.log.multi = 1'b1;
          end
          else
          begin
            s_d.log.valid = 1'b1;
            s_d.log.wr = ireq[w].wr;
            s_d.log.region = rr[1:0];
            s_d.log.tgt = 4'(t);
            s_d.log.init_id = init_id(int'(w), thigh[t][w]);
            s_d.log.grp = g;
          end
        end
      end
    end
    // APB decode; rr is free again once logging is done
    rr = {2'h0, off[5:4]};
    rvalid = paddr[11:0] >= sbarb_pkg::OFS_REGION && rt < 4'hd
             && rr < 4'h3 && rw < 4'h3 && paddr[31:12] == 20'h0
             && off[11:10] == 2'h0;
    if (psel && !penable)
    begin
      s_d.slverr = 1'b0;
      s_d.rdata = '0;
      unique case (paddr[11:0])
        sbarb_pkg::OFS_CFG0:
          s_d.rdata[sbarb_pkg::CFG0_CPU:sbarb_pkg::CFG0_FC] = s_q.hi_sel;
        sbarb_pkg::OFS_CFG: s_d.rdata[sbarb_pkg::CFG_LOCK] = s_q.lock;
        sbarb_pkg::OFS_GRP: s_d.rdata = {4'h0, s_q.grp};
        sbarb_pkg::OFS_KEY: s_d.rdata = '0;
        sbarb_pkg::OFS_LOG: s_d.rdata = 32'(s_q.log);
        sbarb_pkg::OFS_LOGCLR: s_d.rdata = '0;
        default:
        begin
          s_d.slverr = !rvalid;
          if (rvalid && rw == sbarb_pkg::WORD_DESC)
          begin
            s_d.rdata = {eff_desc(s_q, int'(rt), int'(rr)), 4'h0};
          end
          else if (rvalid)
          begin
            s_d.rdata = {28'h0, eff_perm(s_q, int'(rt), int'(rr),
                                         rw == sbarb_pkg::WORD_WR)};
          end
        end
      endcase
    end
    if (wen)
    begin
      unique case (paddr[11:0])
        sbarb_pkg::OFS_CFG0:
          s_d.hi_sel = pwdata[sbarb_pkg::CFG0_CPU:sbarb_pkg::CFG0_FC];
        sbarb_pkg::OFS_CFG:
        begin
          // Lock bit moves only when the key pair armed it
          if (s_q.key_state == 2'h2)
          begin
            s_d.lock = pwdata[sbarb_pkg::CFG_LOCK];
          end
          s_d.key_state = 2'h0;
        end
        sbarb_pkg::OFS_GRP: s_d.grp = pwdata[27:0];
        sbarb_pkg::OFS_KEY:
        begin
          if (pwdata == sbarb_pkg::KEY_FIRST)
          begin
            s_d.key_state = 2'h1;
          end
          else if (s_q.key_state == 2'h1 && pwdata == sbarb_pkg::KEY_SECOND)
          begin
            s_d.key_state = 2'h2;
          end
          else
          begin
            s_d.key_state = 2'h0;
          end
        end
        sbarb_pkg::OFS_LOGCLR:
        begin
          // A violation in the same cycle wins over the clear
          if (!vio_seen)
          begin
            s_d.log = '0;
          end
        end
        default:
        begin
          if (rvalid && !s_q.lock)
          begin
            if (rw == sbarb_pkg::WORD_DESC && rr != 4'h0
                && sbarb_pkg::PROG_TGT[rt])
            begin
              s_d.desc[rt][rr] = pwdata[31:4];
            end
            else if (rw == sbarb_pkg::WORD_RD)
            begin
              s_d.rperm[rt][rr] = pwdata[3:0];
            end
            else if (rw == sbarb_pkg::WORD_WR)
            begin
              s_d.wperm[rt][rr] = pwdata[3:0];
            end
          end
        end
      endcase
    end
    if (nmi_event)
    begin
      s_d.grp[1:0] = 2'h0;
    end
  end

  assign prdata = s_q.rdata;
  assign pslverr = s_q.slverr && psel && penable;
  assign pready = 1'b1;

  always_ff @(posedge clk_sys or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      s_q <= '0;
      for (int t = 0; t < 13; t++)
      begin
        for (int r = 0; r < 3; r++)
        begin
          s_q.rperm[t][r] <= sbarb_pkg::PERM_ALL;
          s_q.wperm[t][r] <= sbarb_pkg::PERM_ALL;
        end
      end
    end
    else
    begin
      s_q <= s_d;
    end
  end

endmodule

// file: sbarb_asserts.sv
/*
  Port checker for sbarb_top: APB answer, routing and arbitration.
  Assumes the bind at the foot; one clock domain, rst_n active low.
*/
`timescale 1ns/1ps
module sbarb_asserts (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire sbarb_pkg::sbarb_ireq_t [13:0] ireq,
  input wire sbarb_pkg::sbarb_iresp_t [13:0] iresp,
  input wire sbarb_pkg::sbarb_tsel_t [12:0] tsel,
  input wire logic nmi_event
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_nmi;
    nmi_event;
  endsequence
  sequence s_grp_rd;
    psel && !penable && !pwrite && paddr == 32'h8;
  endsequence
  property p_ready;
    psel && penable |-> pready;
  endproperty
  property p_err_phase;
    pslverr |-> psel && penable;
  endproperty
  property p_unmapped;
    psel && penable && paddr == 32'h18 |-> pslverr;
  endproperty
  property p_flash;
    tsel[4].valid |-> tsel[4].init == 4'h0 || tsel[4].init == 4'h4;
  endproperty
  property p_cal;
    tsel[8].valid |-> tsel[8].init != 4'h3;
  endproperty
  property p_pref;
    tsel[3].valid |-> !(tsel[3].init inside {4'h1, 4'h3, 4'h4});
  endproperty
  property p_owner;
    tsel[0].valid |-> iresp[tsel[0].init].gnt && !iresp[tsel[0].init].err
      && ireq[tsel[0].init].addr[31:17] == 15'h0;
  endproperty
  // Two winners on one target would corrupt the bank
  property p_one;
    ireq[0].req && ireq[1].req && ireq[0].addr[31:17] == 15'h0
      && ireq[1].addr[31:17] == 15'h0
      |-> !(iresp[0].gnt && !iresp[0].err && iresp[1].gnt && !iresp[1].err);
  endproperty
  // Debugger never runs high; with no SRAM high requester, 13 rivals bound its wait
  property p_bound;
    ireq[4].req && !iresp[4].gnt |-> ##[1:13] iresp[4].gnt;
  endproperty
  property p_nmi;
    s_nmi ##1 s_grp_rd |=> prdata[1:0] == 2'h0;
  endproperty
  a_ready: assert property (p_ready) else $error("pready low in access");
  a_err_phase: assert property (p_err_phase) else $error("stray pslverr");
  a_unmapped: assert property (p_unmapped) else $error("no pslverr");
  a_flash: assert property (p_flash) else $error("flash path bad");
  a_cal: assert property (p_cal) else $error("calendar path bad");
  a_pref: assert property (p_pref) else $error("prefetch path bad");
  a_owner: assert property (p_owner) else $error("bank owner bad");
  a_one: assert property (p_one) else $error("two winners");
  a_bound: assert property (p_bound) else $error("debugger starved");
  a_nmi: assert property (p_nmi) else $error("group not cleared");
endmodule

bind sbarb_top sbarb_asserts i_chk (
  .clk_sys(clk_sys),
  .rst_n(rst_n),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .ireq(ireq),
  .iresp(iresp),
  .tsel(tsel),
  .nmi_event(nmi_event)
);

// file: sbarb_init_model.sv
/*
  One bus initiator: holds a request until granted, records the result.
  Assumes start is a one-cycle pulse given while idle.
*/
`timescale 1ns/1ps
module sbarb_init_model (
  input wire logic clk_sys,
  input wire logic start,
  input wire logic wr,
  input wire logic [31:0] addr,
  input wire sbarb_pkg::sbarb_iresp_t resp,
  output sbarb_pkg::sbarb_ireq_t req_o,
  output logic busy,
  output logic err_q,
  output logic [7:0] wait_q
);
  initial
  begin
    req_o = '0;
    busy = 1'b0;
    err_q = 1'b0;
    wait_q = 8'h00;
  end
  always @(posedge clk_sys)
  begin
    if (busy && resp.gnt)
    begin
      err_q <= resp.err;
      busy <= 1'b0;
      req_o.req <= 1'b0;
      // Released lines must not keep the old value
      req_o.addr <= ~req_o.addr;
      req_o.wr <= ~req_o.wr;
    end
    else if (busy)
      wait_q <= wait_q + 8'h01;
    else if (start)
    begin
      busy <= 1'b1;
      wait_q <= 8'h00;
      req_o <= '{req: 1'b1, wr: wr, addr: addr};
    end
  end
endmodule

// file: sbarb_bench.sv
/*
  Self-checking bench for sbarb_top: APB tasks plus initiator models.
  Assumes zero-wait APB answers and combinational grants.
*/
`timescale 1ns/1ps
module sbarb_bench;
  logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, exc, nmi;
  logic err;
  logic [31:0] paddr, pwdata, prdata, rd;
  wire sbarb_pkg::sbarb_ireq_t [13:0] ireq;
  sbarb_pkg::sbarb_iresp_t [13:0] iresp;
  sbarb_pkg::sbarb_tsel_t [12:0] tsel;
  logic [13:0] start, iwr;
  wire [13:0] busy, ierr;
  logic [31:0] iaddr [14];
  wire [7:0] iwait [14];
  int n_fail, checks;
  logic [31:0] rt_a [3] = '{32'h100, 32'h200, 32'h340};
  logic [31:0] rt_e [3] = '{32'h80, 32'h100000b0, 32'h1f8f0070};
  logic [39:0] ct [6] = '{40'h13_10000000, 40'h04_10000000,
    40'h13_1f870000, 40'h02_1f870000, 40'h11_10800000, 40'h00_10800000};
  logic [23:0] pt [5] = '{24'h200100, 24'h400200, 24'h400300,
    24'h801010, 24'h800011};
  logic [31:0] gt [6] = '{32'h0f01_0000, 32'h0f01_03fc, 32'h0f00_0400,
    32'hf011_0000, 32'hf000_0000, 32'h2f01_0000};

  sbarb_top i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ireq(ireq),
    .iresp(iresp), .tsel(tsel), .cpu_exception_level(exc),
    .nmi_event(nmi));

  for (genvar g = 0; g < 14; g++)
  begin : g_ini
    sbarb_init_model i_ini (.clk_sys(clk_sys), .start(start[g]),
      .wr(iwr[g]), .addr(iaddr[g]), .resp(iresp[g]), .req_o(ireq[g]),
      .busy(busy[g]), .err_q(ierr[g]), .wait_q(iwait[g]));
  end

  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Called just after a rising edge; returns just after one
  task automatic apb(input logic w, input logic [31:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
      @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic set(input int i, input logic w, input logic [31:0] a);
    iwr[i] <= w;
    iaddr[i] <= a;
  endtask

  task automatic go(input logic [13:0] m);
    int n;
    n = 0;
    start <= m;
    @(posedge clk_sys);
    start <= '0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (busy !== 14'h0 && n < 40);
    chk({31'h0, n < 40}, 32'h1);
  endtask

  initial
  begin
    #100000;
    n_fail++;
    end_sim();
  end

  initial
  begin
    rst_n = 1'b0;
    {psel, penable, pwrite, exc, nmi} = '0;
    {paddr, pwdata} = '0;
    {start, iwr} = '0;
    for (int i = 0; i < 14; i++)
      iaddr[i] = '0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    for (int k = 0; k < 3; k++)
    begin
      apb(1'b0, rt_a[k], 32'h0);
      chk(rd & 32'hfffffdf0, rt_e[k]);
    end
    apb(1'b0, 32'h114, 32'h0);
    chk(rd, 32'hf);
    apb(1'b0, 32'h18, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("reset values done");
    for (int k = 0; k < 6; k++)
    begin
      set(ct[k][35:32], 1'b0, ct[k][31:0]);
      go(14'h1 << ct[k][35:32]);
      chk({31'h0, ierr[ct[k][35:32]]}, {31'h0, ct[k][36]});
    end
    set(0, 1'b0, 32'h400);
    set(2, 1'b0, 32'h40000);
    go(14'h5);
    chk({iwait[0], iwait[2]}, 32'h0);
    set(0, 1'b0, 32'h10000000);
    set(4, 1'b0, 32'h10000000);
    go(14'h11);
    chk({24'h0, iwait[0] + iwait[4]}, 32'h1);
    $display("routing done");
    // Short bursts only: high priority starves the rest
    for (int k = 0; k < 5; k++)
    begin
      apb(1'b1, 32'h0, {24'h0, pt[k][23:16]});
      exc <= pt[k][12];
      set(pt[k][11:8], 1'b0, 32'h400);
      go(14'h1 << pt[k][11:8]);
      set(pt[k][7:4], 1'b0, 32'h400);
      go((14'h1 << pt[k][11:8]) | (14'h1 << pt[k][7:4]));
      chk({24'h0, iwait[pt[k][11:8]]}, {28'h0, pt[k][3:0]});
    end
    exc <= 1'b0;
    apb(1'b1, 32'h0, 32'h0);
    $display("arbitration done");
    apb(1'b1, 32'h110, 32'h10);
    for (int k = 0; k < 6; k++)
    begin
      apb(1'b1, 32'h114, {28'h0, gt[k][31:28]});
      apb(1'b1, 32'h118, {28'h0, gt[k][27:24]});
      set(0, gt[k][20], {16'h0, gt[k][15:0]});
      go(14'h1);
      chk({31'h0, ierr[0]}, {31'h0, gt[k][16]});
    end
    apb(1'b1, 32'h8, 32'h1);
    set(0, 1'b0, 32'h0);
    go(14'h1);
    chk({31'h0, ierr[0]}, 32'h0);
    nmi <= 1'b1;
    @(posedge clk_sys);
    nmi <= 1'b0;
    apb(1'b0, 32'h8, 32'h0);
    chk({30'h0, rd[1:0]}, 32'h0);
    go(14'h1);
    chk({31'h0, ierr[0]}, 32'h1);
    $display("regions done");
    apb(1'b1, 32'h4, 32'h800);
    apb(1'b0, 32'h4, 32'h0);
    chk({31'h0, rd[11]}, 32'h0);
    apb(1'b1, 32'hc, sbarb_pkg::KEY_FIRST);
    apb(1'b1, 32'hc, sbarb_pkg::KEY_SECOND);
    apb(1'b1, 32'h4, 32'h800);
    apb(1'b0, 32'h4, 32'h0);
    chk({31'h0, rd[11]}, 32'h1);
    apb(1'b1, 32'h114, 32'hf);
    apb(1'b0, 32'h114, 32'h0);
    chk(rd, 32'h2);
    apb(1'b1, 32'h14, 32'h0);
    set(0, 1'b1, 32'h10000000);
    go(14'h1);
    chk({31'h0, ierr[0]}, 32'h1);
    apb(1'b0, 32'h10, 32'h0);
    chk({16'h0, rd[15:0]}, 32'h0143);
    $display("lock and log done");
    end_sim();
  end
endmodule
